//--- two_wire_pkg.sv
`default_nettype none
package two_wire_pkg;
  // ==========================================================
  // Register map, byte addresses (printed offsets are not word aligned)
  localparam logic [7:0] STATUS_IDX = 8'hb9;
  localparam logic [7:0] DATA_IDX = 8'hbb;
  localparam logic [7:0] CTRL_IDX = 8'hbc;
  localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [9:0] DATA_ADDR = {DATA_IDX, 2'b00};
  localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [7:0] STATUS_RESET = 8'hf8;
  localparam logic [7:0] DATA_RESET = 8'hff;
  // Control register bit positions
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_ACKEN_BIT = 6;
  localparam int CTRL_BEGIN_BIT = 5;
  localparam int CTRL_HALT_BIT = 4;
  // ==========================================================
  // State codes, upper five bits of the status byte
  localparam logic [4:0] ST_START = 5'h01;
  localparam logic [4:0] ST_RESTART = 5'h02;
  localparam logic [4:0] ST_ARB_LOST = 5'h07;
  localparam logic [4:0] ST_ADDR_ACK = 5'h08;
  localparam logic [4:0] ST_ADDR_NACK = 5'h09;
  localparam logic [4:0] ST_DATA_ACK = 5'h0a;
  localparam logic [4:0] ST_DATA_NACK = 5'h0b;
  localparam logic [4:0] ST_IDLE = 5'h1f;
  // ==========================================================
  // Timing: quarter bit period in system clocks before prescaling
  localparam int QUARTER_NS = 1250;
  localparam int CLK_NS = 10;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  // Bus pins carried together
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_type;
endpackage : two_wire_pkg
`default_nettype wire

//--- two_wire_master_receiver.sv
// Behaviour
// - Data changes only while clock low.
// - After start report 0x08, send address.
// - After repeated start report 0x10.
// - Arbitration lost reports 0x38, release bus.
// - Address acked reports 0x40, receive byte.
// - Address nacked reports 0x48, start/stop options.
// - Byte acked reports 0x50.
// - Byte nacked reports 0x58, start/stop options.
// - Status code in upper five bits.
// - Status bit two reads zero.
// - Low bits select divide 1/4/16/64.
// - Data register holds byte sent/received.
// - Data writable and stable only when done.
// - Bus data shifted in while shifting out.
// - Data byte kept on arbitration loss.
// - Acknowledge handled by hardware only.
// - Address byte: seven bits plus direction.
//
// Added by the designer: register access over Wishbone.
`default_nettype none
module two_wire_master_receiver
  import two_wire_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Open-drain bus pins, enable low drives low
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Hand-off to the transmitter part
  output logic xmit_mode_o
);
  // ==========================================================
  // Phase sequencer states
  typedef enum logic [7:0] {
    PH_IDLE = 8'b0000_0001,
    PH_START = 8'b0000_0010,
    PH_BIT = 8'b0000_0100,
    PH_STOP = 8'b0000_1000,
    PH_WAIT = 8'b0001_0000,
    PH_WFREE = 8'b0010_0000,
    PH_XMIT = 8'b0100_0000,
    PH_SLAVE = 8'b1000_0000
  } phase_type;
  phase_type phase_q;
  bus_pins_type sync1_q, sync2_q, pins;
  logic [4:0] code_q;
  logic [1:0] presc_q;
  logic [7:0] data_q;
  logic done_q, acken_q, begin_q, halt_q, first_q, busy_q;
  logic is_addr_q, restart_q, then_start_q;
  logic [3:0] bit_q;
  logic [1:0] quarter_q;
  logic [13:0] div_q;
  logic [13:0] div_max;
  logic tick;
  logic drv_sda_q, drv_scl_q;
  logic acc, wr;
  logic ctrl_wr;
  logic [7:0] ctrl_rd;
  assign pins = sync2_q;
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge where the master samples ack high, not earlier
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign ctrl_wr = wr & (wb_adr_i == CTRL_ADDR) & wb_dat_i[CTRL_DONE_BIT];
  assign ctrl_rd = {done_q, acken_q, begin_q, halt_q, 4'h0};
  // ==========================================================
  // Two-stage pin synchroniser
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= {scl_i, sda_i};
      sync2_q <= sync1_q;
    end
  end
  // Prescaled quarter-bit tick
  always_comb begin
    unique case (presc_q)
      2'b00: div_max = 14'(QUARTER_CYC);
      2'b01: div_max = 14'(QUARTER_CYC * 4);
      2'b10: div_max = 14'(QUARTER_CYC * 16);
      2'b11: div_max = 14'(QUARTER_CYC * 64);
    endcase
  end
  assign tick = (div_q >= div_max - 14'h0001);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !busy_q) begin
      div_q <= 14'h0000;
    end else if (tick) begin
      div_q <= 14'h0000;
    end else begin
      div_q <= div_q + 14'h0001;
    end
  end
  // ==========================================================
  // Wishbone answer, registered ack one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc) begin
        unique case (wb_adr_i)
          STATUS_ADDR: wb_dat_o <= {24'h0, code_q, 1'b0, presc_q};
          DATA_ADDR: wb_dat_o <= {24'h0, data_q};
          CTRL_ADDR: wb_dat_o <= {24'h0, ctrl_rd};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Prescaler select
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      presc_q <= STATUS_RESET[1:0];
    end else if (wr && wb_adr_i == STATUS_ADDR) begin
      presc_q <= wb_dat_i[1:0];
    end
  end
  // Control bits latched on each step launch
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      acken_q <= 1'b0;
      begin_q <= 1'b0;
      first_q <= 1'b0;
    end else if (ctrl_wr) begin
      acken_q <= wb_dat_i[CTRL_ACKEN_BIT];
      begin_q <= wb_dat_i[CTRL_BEGIN_BIT];
    end
    if (!rst_i && done_q) begin
      first_q <= 1'b1;
    end
  end
  // ==========================================================
  // Main sequencer: bits, conditions, status codes, data shifter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase_q <= PH_IDLE;
      code_q <= ST_IDLE;
      data_q <= DATA_RESET;
      done_q <= 1'b0;
      halt_q <= 1'b0;
      busy_q <= 1'b0;
      bit_q <= 4'h0;
      quarter_q <= 2'b00;
      is_addr_q <= 1'b0;
      restart_q <= 1'b0;
      then_start_q <= 1'b0;
      drv_sda_q <= 1'b0;
      drv_scl_q <= 1'b0;
      xmit_mode_o <= 1'b0;
    end else begin
      // Data writable by software only while the done flag is set
      if (wr && wb_adr_i == DATA_ADDR && done_q && first_q) begin
        data_q <= wb_dat_i[7:0];
      end
      unique case (phase_q)
        PH_IDLE, PH_WAIT, PH_SLAVE: begin
          if (ctrl_wr) begin
            done_q <= 1'b0;
            halt_q <= wb_dat_i[CTRL_HALT_BIT];
            then_start_q <= wb_dat_i[CTRL_HALT_BIT] & wb_dat_i[CTRL_BEGIN_BIT];
            busy_q <= 1'b1;
            quarter_q <= 2'b00;
            if (phase_q == PH_SLAVE && wb_dat_i[CTRL_BEGIN_BIT]) begin
              phase_q <= PH_WFREE;
            end else if (wb_dat_i[CTRL_HALT_BIT]) begin
              phase_q <= PH_STOP;
            end else if (wb_dat_i[CTRL_BEGIN_BIT]) begin
              restart_q <= (phase_q == PH_WAIT);
              phase_q <= PH_START;
            end else if (phase_q == PH_WAIT &&
                         (code_q == ST_START || code_q == ST_RESTART) &&
                         !data_q[0] && code_q == ST_RESTART) begin
              phase_q <= PH_XMIT;
              xmit_mode_o <= 1'b1;
              busy_q <= 1'b0;
            end else if (phase_q == PH_WAIT) begin
              is_addr_q <= (code_q == ST_START || code_q == ST_RESTART);
              bit_q <= 4'h0;
              phase_q <= PH_BIT;
            end else begin
              busy_q <= 1'b0;
              phase_q <= PH_IDLE;
            end
          end
        end
        PH_WFREE: begin
          if (pins.scl && pins.sda) begin
            restart_q <= 1'b0;
            phase_q <= PH_START;
          end
        end
        PH_START: if (tick) begin
          quarter_q <= quarter_q + 2'b01;
          // Release, then pull data low while clock high, then clock low
          unique case (quarter_q)
            2'b00: begin drv_sda_q <= 1'b0; drv_scl_q <= 1'b0; end
            2'b01: drv_sda_q <= 1'b1;
            2'b10: drv_scl_q <= 1'b1;
            2'b11: begin
              code_q <= restart_q ? ST_RESTART : ST_START;
              done_q <= 1'b1;
              busy_q <= 1'b0;
              phase_q <= PH_WAIT;
            end
          endcase
        end
        PH_BIT: if (tick) begin
          quarter_q <= quarter_q + 2'b01;
          unique case (quarter_q)
            // Data set only with clock low
            2'b00: begin
              if (bit_q < 4'h8) begin
                drv_sda_q <= is_addr_q ? ~data_q[7] : 1'b0;
              end else begin
                drv_sda_q <= is_addr_q ? 1'b0 : acken_q;
              end
            end
            2'b01: drv_scl_q <= 1'b0;
            2'b10: begin
              if (bit_q < 4'h8) begin
                data_q <= {data_q[6:0], pins.sda};
              end
              // Lost arbitration: we released but line low; byte kept
              if (is_addr_q && !drv_sda_q && !pins.sda && (bit_q < 4'h8 ? data_q[7] : 1'b0)) begin
                code_q <= ST_ARB_LOST;
                drv_sda_q <= 1'b0;
                drv_scl_q <= 1'b0;
                done_q <= 1'b1;
                busy_q <= 1'b0;
                phase_q <= PH_SLAVE;
              end else if (bit_q == 4'h8) begin
                if (is_addr_q) begin
                  code_q <= pins.sda ? ST_ADDR_NACK : ST_ADDR_ACK;
                end else begin
                  code_q <= acken_q ? ST_DATA_ACK : ST_DATA_NACK;
                end
              end
            end
            2'b11: begin
              drv_scl_q <= 1'b1;
              if (phase_q == PH_BIT && bit_q == 4'h8) begin
                // Ack level kept past the falling clock; next bit releases it
                done_q <= 1'b1;
                busy_q <= 1'b0;
                phase_q <= PH_WAIT;
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          endcase
        end
        PH_STOP: if (tick) begin
          quarter_q <= quarter_q + 2'b01;
          unique case (quarter_q)
            2'b00: drv_sda_q <= 1'b1;
            2'b01: drv_scl_q <= 1'b0;
            2'b10: drv_sda_q <= 1'b0;
            2'b11: begin
              halt_q <= 1'b0;
              restart_q <= 1'b0;
              phase_q <= then_start_q ? PH_START : PH_IDLE;
              busy_q <= then_start_q;
              code_q <= ST_IDLE;
            end
          endcase
        end
        PH_XMIT: phase_q <= PH_XMIT;
        default: phase_q <= PH_IDLE;
      endcase
    end
  end
  // Pins from flops; enable low while pulling low
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n_o <= ~drv_scl_q;
      sda_oe_n_o <= ~drv_sda_q;
    end
  end
endmodule : two_wire_master_receiver
`default_nettype wire

//--- two_wire_master_receiver_sva.sv
`default_nettype none
// ==========================================================
// Register bus and pin checks at the top ports
module two_wire_master_receiver_sva
  import two_wire_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic scl_o,
  input wire logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic rd_st;
  logic rd_bad;
  logic [1:0] presc_q;
  // Decoded requests
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_st = req && !wb_we_i && wb_adr_i == STATUS_ADDR;
  assign rd_bad = req && !wb_we_i && !(wb_adr_i inside {STATUS_ADDR, DATA_ADDR, CTRL_ADDR});
  // Shadow of the divider select, so readback is judged against the last write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      presc_q <= STATUS_RESET[1:0];
    else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == STATUS_ADDR)
      presc_q <= wb_dat_i[1:0];
  end
  a_ack_after_req: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_status_bit_two: assert property (rd_st |=> wb_dat_o[2] == 1'b0)
    else $error("status bit two set");
  a_presc_readback: assert property (rd_st |=> wb_dat_o[1:0] == presc_q)
    else $error("divider select readback wrong");
  a_upper_lanes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  a_unmapped_zero: assert property (rd_bad |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_dat_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved between accesses");
  a_pins_pull_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin output level not low");
endmodule : two_wire_master_receiver_sva
bind two_wire_master_receiver two_wire_master_receiver_sva chk (.ref_clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .scl_o, .sda_o);
`default_nettype wire

//--- two_wire_slave_model.sv
`default_nettype none
// ==========================================================
// Addressed slave: acks its read address, then sends bytes until nacked
module two_wire_slave_model
  import two_wire_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
  // Bus levels in, data pull-down out
  input wire bus_pins_type bus_i,
  output logic sda_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [7:0] tx;
  logic more;
  // Behavioural byte engine; released line floats high on the pull-up
  always begin : serve
    sda_oe_n_o = 1'b1;
    @(negedge bus_i.sda iff bus_i.scl === 1'b1);
    repeat (8) @(posedge bus_i.scl) sh = {sh[6:0], bus_i.sda};
    if (sh[7:1] == DEV_ADDR && sh[0] == 1'b1) begin
      @(negedge bus_i.scl) sda_oe_n_o = 1'b0;
      tx = 8'h96;
      more = 1'b1;
      while (more) begin
        // Data moves only while the clock is low
        for (int i = 7; i >= 0; i--) @(negedge bus_i.scl) sda_oe_n_o = tx[i];
        @(negedge bus_i.scl) sda_oe_n_o = 1'b1;
        @(posedge bus_i.scl) more = !bus_i.sda;
        tx = ~tx;
      end
    end
  end
endmodule : two_wire_slave_model
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb
  import two_wire_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
  localparam logic [6:0] SLV = 7'h2a;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, scl_oe_n, sda_oe_n, slv_oe_n, xmit;
  bus_pins_type bus;
  int n_errors = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  // Wired-AND bus with pull-ups
  assign bus = {scl_oe_n, sda_oe_n & slv_oe_n};
  always #5 ref_clk_i = ~ref_clk_i;
  two_wire_master_receiver uut (.ref_clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .scl_i(bus.scl), .sda_i(bus.sda), .scl_o(), .scl_oe_n_o(scl_oe_n),
    .sda_o(), .sda_oe_n_o(sda_oe_n), .xmit_mode_o(xmit));
  two_wire_slave_model #(.DEV_ADDR(SLV)) slv (.bus_i(bus), .sda_oe_n_o(slv_oe_n));
  // ==========================================================
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge ref_clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Launch a step, poll a control bit, then read the status masked
  task automatic step(input logic [7:0] c, input int b, input logic lvl);
    wb(1'b1, CTRL_ADDR, c);
    do wb(1'b0, CTRL_ADDR, 8'h00); while (rdat[b] !== lvl);
    wb(1'b0, STATUS_ADDR, 8'h00);
    rdat = rdat & 32'hf8;
  endtask : step
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Hang guard, a few times the expected traffic length
  always @(posedge ref_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wb(1'b0, STATUS_ADDR, 8'h00);
    `CHK(rdat, 32'hf8)
    wb(1'b0, DATA_ADDR, 8'h00);
    `CHK(rdat, 32'hff)
    wb(1'b0, 10'h004, 8'h00);
    `CHK(rdat, 32'h0)
    // Walk the divider select down so the bus runs undivided afterwards
    for (int i = 3; i >= 0; i--) begin
      wb(1'b1, STATUS_ADDR, 8'(i));
      wb(1'b0, STATUS_ADDR, 8'h00);
      `CHK(rdat, 32'hf8 | 32'(i))
    end
    wb(1'b1, DATA_ADDR, 8'h55);
    wb(1'b0, DATA_ADDR, 8'h00);
    `CHK(rdat, 32'hff)
    $display("test registers done");
    step(8'ha0, CTRL_DONE_BIT, 1'b1);
    `CHK(rdat, 32'h08)
    wb(1'b1, DATA_ADDR, {SLV, 1'b1});
    wb(1'b0, DATA_ADDR, 8'h00);
    `CHK(rdat[7:0], {SLV, 1'b1})
    step(8'hc0, CTRL_DONE_BIT, 1'b1);
    `CHK(rdat, 32'h40)
    step(8'hc0, CTRL_DONE_BIT, 1'b1);
    `CHK(rdat, 32'h50)
    wb(1'b0, DATA_ADDR, 8'h00);
    `CHK(rdat, 32'h96)
    step(8'h80, CTRL_DONE_BIT, 1'b1);
    `CHK(rdat, 32'h58)
    wb(1'b0, DATA_ADDR, 8'h00);
    `CHK(rdat, 32'h69)
    step(8'h90, CTRL_HALT_BIT, 1'b0);
    `CHK(rdat, 32'hf8)
    $display("test read transfer done");
    step(8'ha0, CTRL_DONE_BIT, 1'b1);
    `CHK(rdat, 32'h08)
    wb(1'b1, DATA_ADDR, {SLV ^ 7'h01, 1'b1});
    step(8'h80, CTRL_DONE_BIT, 1'b1);
    `CHK(rdat, 32'h48)
    step(8'ha0, CTRL_DONE_BIT, 1'b1);
    `CHK(rdat, 32'h10)
    wb(1'b1, DATA_ADDR, {SLV, 1'b0});
    wb(1'b1, CTRL_ADDR, 8'h80);
    for (int i = 0; i < 6000 && xmit !== 1'b1; i++) @(posedge ref_clk_i);
    `CHK(xmit, 1'b1)
    $display("test address refusal and hand-off done");
    end_sim();
  end
`undef CHK
endmodule : tb
`default_nettype wire
